// file: bench/etm_pulse_src.sv
// etm_pulse_src: model of the external pulse source driving the event inputs
// assumes the bench calls pulse() from a process that runs on pclk
`timescale 1ns/1ps
module etm_pulse_src import etm_pkg::*; (
  // clock
  input wire logic pclk,
  // event levels
  output logic [NCH-1:0] level
);
  initial begin
    level = '0;
  end

  // a pulse holds each line for whole clock cycles, so no level is shorter than
  // one cycle and the synchroniser never misses it
  task automatic pulse(input logic [NCH-1:0] m, input int w);
    @(posedge pclk);
    level <= level | m;
    repeat (w) @(posedge pclk);
    level <= level & ~m;
  endtask
endmodule // etm_pulse_src

// file: bench/etm_timemark_tb.sv
// etm_timemark_tb: self-checking bench, apb reads and writes plus event pulses
// assumes one 10 MHz pclk; the pulse source model drives the event inputs
`timescale 1ns/1ps
module etm_timemark_tb import etm_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, report_pulse, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic [NCH-1:0] ev;
  int num_errors, n_checks, cyc, rep_n, rep_cyc;

  etm_timemark i_etm_timemark (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_event_input(ev), .report_pulse(report_pulse), .irq(irq));
  etm_pulse_src i_etm_pulse_src (.pclk(pclk), .level(ev));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // monitor and hang limit
  // ----------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (report_pulse === 1'b1) begin
      rep_n <= rep_n + 1;
      rep_cyc <= cyc;
    end
    if (cyc == 106000) begin
      num_errors++;
      end_sim();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look at pready mid-cycle so the value is settled before the sampling edge
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) num_errors++;
    q = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, {24'h00_0000, a}, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, {24'h00_0000, a}, 32'h0000_0000, q, e);
  endtask

  // times flattened to cycles so ms carries never upset a difference
  function automatic logic [63:0] tv(input logic [31:0] m, input logic [31:0] s);
    return {32'h0000_0000, m} * 64'(CYC_PER_MS) + {48'h0000_0000_0000, s[15:0]};
  endfunction

  task automatic rd_ent(input int i, output logic [63:0] t, output logic [31:0] inf);
    logic [31:0] m;
    wr(OFS_RAW_IDX, 32'(i));
    rd(OFS_RAW_MS, m);
    rd(OFS_RAW_INFO, inf);
    t = tv(m, inf);
  endtask

  task automatic rd_rep(output logic [63:0] rt, output logic [63:0] ft,
                        output logic [31:0] fl);
    logic [31:0] m, s;
    rd(OFS_RISE_MS, m);
    rd(OFS_RISE_SUB, s);
    rt = tv(m, s);
    rd(OFS_FALL_MS, m);
    rd(OFS_FALL_SUB, s);
    ft = tv(m, s);
    rd(OFS_REP_FLAGS, fl);
  endtask

  task automatic wait_rep();
    int n0, k;
    n0 = rep_n;
    k = 0;
    while (rep_n == n0 && k < 25000) begin
      @(posedge pclk);
      k++;
    end
    chk("report_pulse", 1, rep_n != n0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r, inf, fl, tw0;
    logic [63:0] rt, ft, e2, e3, d0;
    logic e;
    int last;
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    {num_errors, n_checks, cyc, rep_n, rep_cyc} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, r); chk("ctrl", 0, r);
    rd(OFS_RATE, r); chk("rate", RATE_RST, r);
    rd(OFS_RAW_STAT, r); chk("raw_stat", 0, r);
    apb(1'b1, 32'h0000_0080, 32'h0000_0001, r, e); chk("pslverr", 1, e);
    // one-ms epochs keep the run short
    wr(OFS_RATE, 32'h0000_0001);
    wr(OFS_INT_MASK, 32'h0000_0001);
    wr(OFS_TOW, 32'h0000_0005);
    wr(OFS_CTRL, 32'h0000_001B);
    i_etm_pulse_src.pulse(2'b01, 20);
    wait_rep();
    wr(OFS_CTRL, 32'h0000_001B);
    i_etm_pulse_src.pulse(2'b01, 20);
    i_etm_pulse_src.pulse(2'b01, 30);
    wait_rep();
    rd_rep(rt, ft, fl);
    rd_ent(2, e2, inf); chk("ent2 kind", 2'b10, inf[17:16]);
    rd_ent(3, e3, inf); chk("ent3 kind", 2'b00, inf[17:16]);
    chk("width", 30, e3 - e2);
    d0 = ft - e3;
    chk("mark vs raw", 0, d0);
    chk("newest rise", 0, rt - e2);
    chk("flags", 3'b011, fl[2:0]);
    chk("valid", 1, fl[6]);
    chk("marks", 6, fl[31:16]);
    rd(OFS_REP_ACC, r); chk("accuracy", ACCURACY_NS, r);
    chk("irq on", 1, irq);
    wr(OFS_INT_MASK, 32'h0000_0000);
    rd(OFS_INT_STAT, r); chk("int_stat", 1, r[0]);
    chk("irq masked", 0, irq);
    wr(OFS_INT_STAT, 32'h0000_0001);
    wr(OFS_INT_MASK, 32'h0000_0001);
    rd(OFS_INT_STAT, r); chk("int_clr", 0, r[0]);
    chk("irq clr", 0, irq);
    wr(OFS_CABLE, 32'h0000_0003);
    wr(OFS_USER, 32'h0000_0001);
    wr(OFS_REF, 32'h0000_0007);
    for (int s = 0; s < 6; s++) begin
      wr(OFS_CTRL, 32'h0000_0011 | 32'(s << 1));
      i_etm_pulse_src.pulse(2'b11, 10);
      wait_rep();
      rd(OFS_TOW, r);
      if (s > 0) begin
        chk("epoch gap", 64'(CYC_PER_MS), rep_cyc - last);
        chk("tow step", 1, r - tw0);
      end
      last = rep_cyc;
      tw0 = r;
      rd_rep(rt, ft, fl);
      chk("src", s, fl[5:3]);
      chk("last ch", 1, fl[2]);
      rd_ent(0, e2, inf); chk("ch0 entry", 2'b10, inf[17:16]);
      rd_ent(1, e2, inf); chk("ch1 entry", 2'b11, inf[17:16]);
      rd_ent(3, e3, inf);
      chk("comp", d0 - 2 + (s == 5 ? 0 : 7 * CYC_PER_MS), ft - e3);
    end
    wr(OFS_CTRL, 32'h0000_001A);
    last = rep_n;
    i_etm_pulse_src.pulse(2'b01, 10);
    repeat (10100) @(posedge pclk);
    chk("no report off", last, rep_n);
    wr(OFS_CTRL, 32'h0000_001B);
    repeat (10100) @(posedge pclk);
    chk("no report idle", last, rep_n);
    repeat (10) i_etm_pulse_src.pulse(2'b01, 3);
    rd(OFS_RAW_STAT, r);
    chk("raw full", 32'h0000_0112, r[31:0]);
    rd(OFS_INT_STAT, r); chk("ovf int", 1, r[1]);
    rd_ent(17, e3, inf); chk("ent17", 2'b00, inf[17:16]);
    rd_ent(18, e3, inf); chk("ent18", 0, inf);
    end_sim();
  end
endmodule // etm_timemark_tb

// file: logic/etm_edge_sync.sv
// etm_edge_sync: two-stage synchroniser and edge detector per event channel
// assumes event levels may change at any time relative to pclk
`timescale 1ns/1ps
module etm_edge_sync import etm_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels in, pulses out
  etm_edge_if.det e
);

  logic [NCH-1:0] meta;
  logic [NCH-1:0] sync;
  logic [NCH-1:0] prev;
  logic [NCH-1:0] next_meta;
  logic [NCH-1:0] next_sync;
  logic [NCH-1:0] next_prev;

  always_comb begin
    next_meta = e.level;
    next_sync = meta;
    next_prev = sync;
  end

  // meta feeds sync only; every decision looks at sync or later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign e.rise[g] = sync[g] & ~prev[g];
    assign e.fall[g] = ~sync[g] & prev[g];

    sync_rise_a: assert property (
      @(posedge pclk) disable iff (!presetn) $rose(e.level[g]) |-> ##2 e.rise[g])
      else $error("rising edge not seen two cycles after the pin");
    sync_fall_a: assert property (
      @(posedge pclk) disable iff (!presetn) $fell(e.level[g]) |-> ##2 e.fall[g])
      else $error("falling edge not seen two cycles after the pin");
  end

endmodule // etm_edge_sync

// file: logic/etm_timemark.sv
// etm_timemark: external event timemark capture with summary report and raw list
// assumes APB master on pclk; event inputs may be asynchronous to pclk
//
// Summary of operation
// - at epoch, report only if enabled and an edge arrived since last epoch
// - per epoch keep only the newest rising and newest falling timestamp
// - at most one report per epoch; epoch length follows measurement rate
// - report holds mark times, new-edge flags, source, validity, count, accuracy
// - raw list keeps up to 18 entries of channel 0/1 and local time
// - raw entries use local time of week, corrected only for the 2-cycle sync latency
// - local time base steps in 1 ms; raw stamps use that base
// - report mark times use the selected time reference
// - cable and user delay compensation applied to report mark times
`timescale 1ns/1ps
module etm_timemark import etm_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external events
  input wire logic [NCH-1:0] external_event_input,
  // report and interrupt
  output logic report_pulse,
  output logic irq
);

  typedef struct packed {
    logic en;
    etm_src_t src;
    logic [15:0] rate;
    logic [13:0] cable;
    logic [13:0] user;
    logic [31:0] ref_ofs;
    etm_time_t now;
    logic tvalid;
    logic [15:0] ep_cnt;
    logic epoch;
    etm_time_t pend_rise;
    etm_time_t pend_fall;
    logic seen_rise;
    logic seen_fall;
    logic last_ch;
    etm_time_t rep_rise;
    etm_time_t rep_fall;
    logic rep_nr;
    logic rep_nf;
    logic rep_ch;
    etm_src_t rep_src;
    logic rep_valid;
    logic [15:0] mark_cnt;
    logic [RAW_AW-1:0] raw_cnt;
    logic raw_ovf;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic [RAW_AW-1:0] raw_idx;
    logic report;
    logic irq;
  } etm_core_t;

  etm_core_t c;
  etm_core_t next_c;
  etm_rec_t raw_mem [RAW_DEPTH];
  logic [NCH-1:0] raw_we;
  logic [RAW_AW-1:0] raw_wi [NCH];
  etm_rec_t raw_wd [NCH];
  logic b_pready;
  logic b_pslverr;
  logic [31:0] b_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic wr;
  logic raw_clr;
  logic ms_tick;
  logic rep_cause;
  logic [15:0] rate_eff;
  logic [NCH-1:0] ev;

  etm_edge_if eif ();
  assign eif.level = external_event_input;

  etm_edge_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .e(eif)
  );

  // moves a time by a signed cycle count and whole ms; delays stay below 2 ms
  function automatic etm_time_t shift_time(etm_time_t t, logic signed [17:0] d,
                                           logic [31:0] add);
    logic signed [17:0] s;
    logic [31:0] m;
    s = $signed({2'b00, t.sub}) + d;
    m = t.ms + add;
    for (int i = 0; i < 2; i++) begin
      if (s < 0) begin
        s = s + $signed(18'(CYC_PER_MS));
        m = m - 32'h0000_0001;
      end else if (s >= $signed(18'(CYC_PER_MS))) begin
        s = s - $signed(18'(CYC_PER_MS));
        m = m + 32'h0000_0001;
      end
    end
    return {m, s[15:0]};
  endfunction

  // ----------------------------------------
  // core state
  // ----------------------------------------
  assign wr = psel & penable & b_pready & pwrite;
  assign raw_clr = wr && (paddr[7:0] == OFS_CTRL) && pwdata[CTRL_RAWCLR];
  assign ms_tick = c.now.sub == 16'(CYC_PER_MS - 1);
  assign rate_eff = (c.rate == 16'h0000) ? 16'h0001 : c.rate;
  assign rep_cause = c.epoch & c.en & (c.seen_rise | c.seen_fall);
  assign ev = eif.rise | eif.fall;

  always_comb begin
    etm_time_t stamp;
    etm_time_t mark;
    logic [31:0] add_ms;
    logic signed [17:0] dly;
    logic [RAW_AW-1:0] idx;
    logic [1:0] w1c;
    logic [1:0] set;
    next_c = c;
    next_c.report = 1'b0;
    raw_we = '0;
    raw_wi = '{default: '0};
    raw_wd = '{default: '0};
    w1c = 2'b00;
    set = 2'b00;
    stamp = shift_time(c.now, RAW_DLY, 32'h0000_0000);
    add_ms = (c.src == SRC_LOCAL) ? 32'h0000_0000 : c.ref_ofs;
    dly = RAW_DLY - $signed({{4{c.cable[13]}}, c.cable})
        + $signed({{4{c.user[13]}}, c.user});
    mark = shift_time(c.now, dly, add_ms);

    // local time base, one step per ms
    if (ms_tick) begin
      next_c.now.sub = '0;
      next_c.now.ms = (c.now.ms == TOW_WRAP_MS - 32'h0000_0001) ? '0
                    : c.now.ms + 32'h0000_0001;
      next_c.ep_cnt = (c.ep_cnt + 16'h0001 >= rate_eff) ? '0 : c.ep_cnt + 16'h0001;
    end else begin
      next_c.now.sub = c.now.sub + 16'h0001;
    end
    next_c.epoch = ms_tick && (c.ep_cnt + 16'h0001 >= rate_eff);

    // epoch close: the report samples the state before this cycle's edges
    if (c.epoch) begin
      if (rep_cause) begin
        next_c.report = 1'b1;
        next_c.rep_rise = c.pend_rise;
        next_c.rep_fall = c.pend_fall;
        next_c.rep_nr = c.seen_rise;
        next_c.rep_nf = c.seen_fall;
        next_c.rep_ch = c.last_ch;
        next_c.rep_src = c.src;
        next_c.rep_valid = c.tvalid;
        set[INT_REPORT] = 1'b1;
      end
      next_c.seen_rise = 1'b0;
      next_c.seen_fall = 1'b0;
    end

    // edges; a later channel in the same cycle wins, the time is the same
    idx = raw_clr ? '0 : c.raw_cnt;
    if (raw_clr) begin
      next_c.raw_ovf = 1'b0;
    end
    for (int i = 0; i < NCH; i++) begin
      if (eif.rise[i]) begin
        next_c.pend_rise = mark;
        next_c.seen_rise = 1'b1;
        next_c.last_ch = 1'(i);
      end
      if (eif.fall[i]) begin
        next_c.pend_fall = mark;
        next_c.seen_fall = 1'b1;
        next_c.last_ch = 1'(i);
      end
      if (ev[i]) begin
        next_c.mark_cnt = next_c.mark_cnt + 16'h0001;
        if (idx < RAW_DEPTH_W) begin
          raw_we[i] = 1'b1;
          raw_wi[i] = idx;
          raw_wd[i] = '{rising: eif.rise[i], ch: 1'(i), t: stamp};
          idx = idx + 5'h01;
        end else begin
          next_c.raw_ovf = 1'b1;
          set[INT_RAWOVF] = 1'b1;
        end
      end
    end
    next_c.raw_cnt = idx;

    // register writes
    if (wr) begin
      case (paddr[7:0])
        OFS_CTRL: begin
          next_c.en = pwdata[CTRL_EN];
          next_c.src = etm_src_t'(pwdata[CTRL_SRC +: 3]);
        end
        OFS_RATE: next_c.rate = pwdata[15:0];
        OFS_CABLE: next_c.cable = pwdata[13:0];
        OFS_USER: next_c.user = pwdata[13:0];
        OFS_REF: next_c.ref_ofs = pwdata;
        OFS_TOW: begin
          next_c.now.ms = pwdata;
          next_c.now.sub = '0;
          next_c.tvalid = 1'b1;
        end
        OFS_INT_STAT: w1c = pwdata[1:0];
        OFS_INT_MASK: next_c.int_mask = pwdata[1:0];
        OFS_RAW_IDX: next_c.raw_idx = pwdata[RAW_AW-1:0];
        default: ;
      endcase
    end
    // a new event outlives a clear in the same cycle
    next_c.int_stat = (c.int_stat & ~w1c) | set;
    next_c.irq = |(next_c.int_stat & next_c.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c <= '0;
      c.rate <= RATE_RST;
    end else begin
      c <= next_c;
    end
  end

  always_ff @(posedge pclk) begin
    for (int i = 0; i < NCH; i++) begin
      if (raw_we[i]) begin
        raw_mem[raw_wi[i]] <= raw_wd[i];
      end
    end
  end

  assign report_pulse = c.report;
  assign irq = c.irq;

  // ----------------------------------------
  // apb slave, one wait state on every access
  // ----------------------------------------
  always_comb begin
    etm_rec_t rec;
    rec = (c.raw_idx < c.raw_cnt) ? raw_mem[c.raw_idx] : '0;
    next_pready = psel & penable & ~b_pready;
    next_pslverr = 1'b0;
    next_prdata = b_prdata;
    if (next_pready) begin
      next_prdata = '0;
      if (paddr[31:8] != '0 || paddr[1:0] != 2'b00) begin
        next_pslverr = 1'b1;
      end else begin
        case (paddr[7:0])
          OFS_CTRL: next_prdata = {28'h000_0000, c.src, c.en};
          OFS_RATE: next_prdata = {16'h0000, c.rate};
          OFS_CABLE: next_prdata = {{18{c.cable[13]}}, c.cable};
          OFS_USER: next_prdata = {{18{c.user[13]}}, c.user};
          OFS_REF: next_prdata = c.ref_ofs;
          OFS_TOW: next_prdata = c.now.ms;
          OFS_INT_STAT: next_prdata = {30'h0000_0000, c.int_stat};
          OFS_INT_MASK: next_prdata = {30'h0000_0000, c.int_mask};
          OFS_RISE_MS: next_prdata = c.rep_rise.ms;
          OFS_RISE_SUB: next_prdata = {16'h0000, c.rep_rise.sub};
          OFS_FALL_MS: next_prdata = c.rep_fall.ms;
          OFS_FALL_SUB: next_prdata = {16'h0000, c.rep_fall.sub};
          OFS_REP_FLAGS: next_prdata = {c.mark_cnt, 9'h000, c.rep_valid, c.rep_src,
                                        c.rep_ch, c.rep_nf, c.rep_nr};
          OFS_REP_ACC: next_prdata = {16'h0000, ACCURACY_NS};
          OFS_RAW_STAT: next_prdata = {23'h00_0000, c.raw_ovf, 3'h0, c.raw_cnt};
          OFS_RAW_IDX: next_prdata = {27'h000_0000, c.raw_idx};
          OFS_RAW_MS: next_prdata = rec.t.ms;
          OFS_RAW_INFO: next_prdata = {14'h0000, rec.rising, rec.ch, rec.t.sub};
          default: next_pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_pready <= 1'b0;
      b_pslverr <= 1'b0;
      b_prdata <= '0;
    end else begin
      b_pready <= next_pready;
      b_pslverr <= next_pslverr;
      b_prdata <= next_prdata;
    end
  end

  assign pready = b_pready;
  assign pslverr = b_pslverr;
  assign prdata = b_prdata;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [31:0] gap;
  logic gap_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= '0;
      gap_ok <= 1'b0;
    end else if (wr && (paddr[7:0] == OFS_RATE || paddr[7:0] == OFS_TOW)) begin
      gap_ok <= 1'b0;
    end else if (c.epoch) begin
      gap <= 32'h0000_0001;
      gap_ok <= 1'b1;
    end else begin
      gap <= gap + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_quiet;
    !report_pulse [*8];
  endsequence
  sequence s_tick_then_count;
    (c.now.sub == 16'h0000) ##1 (!ms_tick [*8]);
  endsequence

  report_emit_a: assert property (rep_cause |=> report_pulse)
    else $error("qualified epoch gave no report");
  report_cause_a: assert property (report_pulse |-> $past(rep_cause))
    else $error("report without enable, epoch or edge");
  report_once_a: assert property (report_pulse |=> s_quiet)
    else $error("two reports in one epoch");
  epoch_gap_a: assert property (c.epoch && gap_ok |->
    gap == 32'(rate_eff) * 32'(CYC_PER_MS))
    else $error("epoch spacing differs from measurement rate");
  rise_latest_a: assert property (eif.rise[1] |=> c.seen_rise && c.last_ch)
    else $error("newest rising edge not kept");
  report_fields_a: assert property (report_pulse |->
    c.rep_src == $past(c.src) && c.rep_valid == $past(c.tvalid))
    else $error("report fields not taken at epoch");
  raw_bound_a: assert property (c.raw_cnt <= RAW_DEPTH_W)
    else $error("raw list above its depth");
  raw_grow_a: assert property (|ev && c.raw_cnt < RAW_DEPTH_W && !raw_clr |=>
    c.raw_cnt > $past(c.raw_cnt))
    else $error("edge with room not recorded");
  ms_step_a: assert property (ms_tick && !wr |=> s_tick_then_count)
    else $error("time base does not step once per ms");
  irq_level_a: assert property (irq == |(c.int_stat & c.int_mask))
    else $error("interrupt missing with unmasked status");

endmodule // etm_timemark

// file: shared/etm_edge_if.sv
// etm_edge_if: raw event levels in, edge pulses out
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface etm_edge_if;
  import etm_pkg::*;
  logic [NCH-1:0] level;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  modport det (input level, output rise, output fall);
  modport core (output level, input rise, input fall);
endinterface

// file: shared/etm_pkg.sv
// etm_pkg: constants and types of the external event timemark block
// assumes one 10 MHz clock and software access over a 32-bit APB slave
package etm_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int MEAS_STEP_US = 1000; // 1 ms measurement step
  localparam int CYC_PER_MS = CLK_MHZ * MEAS_STEP_US;
  localparam int SYNC_LAT = 2; // pin sample to edge pulse, in cycles
  localparam logic signed [17:0] RAW_DLY = -18'(SYNC_LAT);
  localparam logic [31:0] TOW_WRAP_MS = 32'h240C_8400; // one week in ms

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NCH = 2;
  localparam int RAW_DEPTH = 18;
  localparam int RAW_AW = 5;
  localparam logic [RAW_AW-1:0] RAW_DEPTH_W = 5'(RAW_DEPTH);

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_CABLE = 8'h08;
  localparam logic [7:0] OFS_USER = 8'h0C;
  localparam logic [7:0] OFS_REF = 8'h10;
  localparam logic [7:0] OFS_TOW = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1C;
  localparam logic [7:0] OFS_RISE_MS = 8'h20;
  localparam logic [7:0] OFS_RISE_SUB = 8'h24;
  localparam logic [7:0] OFS_FALL_MS = 8'h28;
  localparam logic [7:0] OFS_FALL_SUB = 8'h2C;
  localparam logic [7:0] OFS_REP_FLAGS = 8'h30;
  localparam logic [7:0] OFS_REP_ACC = 8'h34;
  localparam logic [7:0] OFS_RAW_STAT = 8'h38;
  localparam logic [7:0] OFS_RAW_IDX = 8'h3C;
  localparam logic [7:0] OFS_RAW_MS = 8'h40;
  localparam logic [7:0] OFS_RAW_INFO = 8'h44;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_SRC = 1;
  localparam int CTRL_RAWCLR = 4;
  localparam int INT_REPORT = 0;
  localparam int INT_RAWOVF = 1;
  localparam logic [15:0] RATE_RST = 16'h03E8;
  localparam logic [15:0] ACCURACY_NS = 16'h0064; // one clock period

  typedef enum logic [2:0] {
    SRC_UTC = 3'b000,
    SRC_GPS = 3'b001,
    SRC_GLO = 3'b010,
    SRC_BDS = 3'b011,
    SRC_GAL = 3'b100,
    SRC_LOCAL = 3'b101
  } etm_src_t;

  typedef struct packed {
    logic [31:0] ms;
    logic [15:0] sub;
  } etm_time_t;

  typedef struct packed {
    logic rising;
    logic ch;
    etm_time_t t;
  } etm_rec_t;

endpackage
